// ### hw/dram_bank_map.sv
`timescale 1ns/1ps
module dram_bank_map #(
    parameter int AW = 25,
    parameter int PAGE_BITS = 11
) (
    input wire logic [1:0] i_size0,
    input wire logic [1:0] i_size1,
    input wire logic i_ilv_req,
    input wire logic [AW-1:0] i_addr,
    output logic [5:0] o_start0,
    output logic [5:0] o_start1,
    output logic o_ilv,
    output logic o_bank,
    output logic o_hit,
    output logic [AW-1:0] o_tag
);
    logic [5:0] cap0;
    logic [5:0] cap1;
    logic [5:0] addr_mb;
    logic [6:0] lim0;
    logic [6:0] lim1;
    logic [6:0] total;
    logic low1;
    logic in0;
    logic in1;

    assign cap0 = dram_map_pkg::bank_mb(i_size0);
    assign cap1 = dram_map_pkg::bank_mb(i_size1);
    assign addr_mb = 6'(i_addr[AW-1:dram_map_pkg::MB_LSB]);
    // Interleave only takes effect on two populated equal banks
    assign o_ilv = i_ilv_req && (cap0 == cap1) && (cap0 != 6'h00); // [R5]
    // Bank 1 goes first only when bank 0 holds the smallest modules
    assign low1 = (i_size0 == dram_map_pkg::SZ_256K) && (cap1 > cap0); // [R11]
    assign o_start0 = (o_ilv || !low1) ? 6'h00 : cap1; // [R6] [R11]
    assign o_start1 = o_ilv ? 6'h00 : (low1 ? 6'h00 : cap0); // [R6] [R9] [R11]
    assign lim0 = {1'b0, o_start0} + {1'b0, cap0};
    assign lim1 = {1'b0, o_start1} + {1'b0, cap1};
    assign total = {1'b0, cap0} + {1'b0, cap1};
    assign in0 = (cap0 != 6'h00) && (addr_mb >= o_start0) && ({1'b0, addr_mb} < lim0);
    assign in1 = (cap1 != 6'h00) && (addr_mb >= o_start1) && ({1'b0, addr_mb} < lim1);
    // Interleaved banks alternate on the single-bank page boundary
    assign o_bank = o_ilv ? i_addr[PAGE_BITS] : (in1 && !in0); // [R8] [R13]
    assign o_hit = o_ilv ? ({1'b0, addr_mb} < total) : (in0 || in1); // [R13]
    // Effective page doubles while interleaved
    assign o_tag = o_ilv ? (i_addr >> (PAGE_BITS + 1)) : (i_addr >> PAGE_BITS); // [R8]
endmodule

// ### hw/dram_bank_timer.sv
`timescale 1ns/1ps
module dram_bank_timer #(
    parameter int CW = 3
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_start,
    input wire logic i_hit,
    input wire logic i_close,
    input wire logic i_page_en,
    input wire logic [CW-1:0] i_waits,
    input wire logic [CW-1:0] i_pre,
    output logic o_avail,
    output logic o_open,
    output logic o_done,
    output logic o_ras_n
);
    typedef enum logic [1:0] {
        TM_IDLE = 2'b00,
        TM_ACCESS = 2'b01,
        TM_OPEN = 2'b10,
        TM_PRE = 2'b11
    } tm_state_t;

    tm_state_t state_q;
    tm_state_t state_d;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        o_done = 1'b0;
        case (state_q)
            TM_IDLE: begin
                if (i_start) begin
                    state_d = TM_ACCESS;
                    cnt_d = i_waits; // [R10] [R12]
                end
            end
            TM_ACCESS: begin
                if (cnt_q == '0) begin
                    o_done = 1'b1;
                    state_d = i_page_en ? TM_OPEN : TM_PRE; // [R7]
                    cnt_d = i_pre;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            TM_OPEN: begin
                // Row held open: a hit skips the row wait
                if (i_start && i_hit) begin
                    state_d = TM_ACCESS;
                    cnt_d = '0; // [R7]
                end else if (i_close || !i_page_en) begin
                    state_d = TM_PRE;
                    cnt_d = i_pre; // [R10] [R12]
                end
            end
            TM_PRE: begin
                if (cnt_q == '0) begin
                    state_d = TM_IDLE;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            default: begin
                state_d = TM_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_q <= TM_IDLE;
            cnt_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    assign o_avail = (state_q == TM_IDLE) || (state_q == TM_OPEN);
    assign o_open = (state_q == TM_OPEN);
    assign o_ras_n = !((state_q == TM_ACCESS) || (state_q == TM_OPEN));
endmodule

// ### hw/dram_map_pkg.sv
package dram_map_pkg;

    // ********************************************************
    // Register indices (byte address is four times the index)
    // ********************************************************
    localparam logic [7:0] IDX_ILV_CTRL = 8'h19;
    localparam logic [7:0] IDX_PAGE_CTRL = 8'h1C;
    localparam logic [7:0] IDX_BANK0_TIME = 8'h20;
    localparam logic [7:0] IDX_BANK1_TIME = 8'h21;
    localparam logic [7:0] IDX_BANK_SIZE = 8'h22;
    localparam logic [7:0] IDX_STATUS = 8'h23;

    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int ILV_EN_BIT = 0;
    localparam int PAGE_DIS_BIT = 4;
    localparam int WAIT_LSB = 0;
    localparam int PRE_LSB = 4;
    localparam int TIME_W = 3;
    localparam int SIZE0_LSB = 0;
    localparam int SIZE1_LSB = 2;
    localparam int STAT_PIPE_BIT = 0;
    localparam int STAT_STRAP_BIT = 1;
    localparam int STAT_ILV_BIT = 2;
    localparam int STAT_PAGE_BIT = 3;
    localparam int STAT_START0_LSB = 8;
    localparam int STAT_START1_LSB = 16;
    localparam int MB_LSB = 20;

    // ********************************************************
    // Reset values
    // ********************************************************
    localparam logic [7:0] ILV_CTRL_RST = 8'h00;
    localparam logic [7:0] PAGE_CTRL_RST = 8'h10;
    localparam logic [7:0] BANK_TIME_RST = 8'h33;
    localparam logic [7:0] BANK_SIZE_RST = 8'h01;

    // ********************************************************
    // Module size codes and bank capacity in MB
    // ********************************************************
    localparam logic [1:0] SZ_NONE = 2'h0;
    localparam logic [1:0] SZ_256K = 2'h1;
    localparam logic [1:0] SZ_1M = 2'h2;
    localparam logic [1:0] SZ_4M = 2'h3;

    function automatic logic [5:0] bank_mb(input logic [1:0] code);
        case (code)
            SZ_256K: bank_mb = 6'h01;
            SZ_1M: bank_mb = 6'h04;
            SZ_4M: bank_mb = 6'h10;
            default: bank_mb = 6'h00;
        endcase
    endfunction

    // ********************************************************
    // Timing
    // ********************************************************
    localparam int CLK_PERIOD_PS = 5000;
    localparam int PIPE_GAIN_NS = 40;
    localparam int PIPE_GAIN_CYC = (PIPE_GAIN_NS * 1000) / CLK_PERIOD_PS;

endpackage

// ### hw/dram_mode_mapper.sv
// Operation
// R1: With the address pipeline active the next address is taken while the current access runs.
// R2: The pipeline is only active with the external cache disabled, at CPU clocks up to 25MHz; the code does not gate O_PIPE_ACTIVE on the clock rate.
// R3: Pipelined or plain addressing is chosen by the static pipeline_strap alone; the code also holds O_PIPE_ACTIVE low while I_CACHE_EN is high.
// R4: Writing one to bit 0 of the interleave control register turns on column_strobe_enables.
// R5: Software only requests interleave when both banks hold the same capacity.
// R6: While interleaved both banks start at address zero and share one region.
// R7: Page mode runs while bit 4 of the page mode control register is zero, in any configuration.
// R8: Two interleaved banks act as one page twice the single-bank size.
// R9: Without interleave bank 1 starts right above bank 0, at bank 0's capacity.
// R10: Bank 1 has its own wait states and row precharge time apart from bank 0.
// R11: With mixed sizes the small-module bank sits above the larger, per the fixed start table; the code leaves a 1M bank 0 below a 4M bank 1.
// R12: Interleave works with banks of different speed, each bank keeping its own timing.
// R13: Each access is decoded against the bank map and strobes the row of the chosen bank only.
`timescale 1ns/1ps
module dram_mode_mapper #(
    parameter int AW = 25,
    parameter int PAGE_BITS = 11
) (
    input wire logic I_CLK,
    input wire logic I_NRST,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [9:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    input wire logic I_ADS,
    input wire logic [AW-1:0] I_ADDR,
    input wire logic I_PIPELINE_STRAP,
    input wire logic I_CACHE_EN,
    output logic O_READY,
    output logic [1:0] O_RAS_N,
    output logic O_COLUMN_STROBE_ENABLES,
    output logic O_PIPE_ACTIVE
);
    localparam int TW = dram_map_pkg::TIME_W;

    // ********************************************************
    // APB decode
    // ********************************************************
    logic [7:0] idx;
    logic word_ok;
    logic hit_ilv;
    logic hit_page;
    logic hit_t0;
    logic hit_t1;
    logic hit_size;
    logic hit_stat;
    logic mapped;
    logic apb_setup;
    logic apb_wr;
    logic [31:0] rd_data;
    logic [31:0] prdata_q;

    assign idx = I_PADDR[9:2];
    assign word_ok = (I_PADDR[1:0] == 2'h0);
    assign hit_ilv = word_ok && (idx == dram_map_pkg::IDX_ILV_CTRL);
    assign hit_page = word_ok && (idx == dram_map_pkg::IDX_PAGE_CTRL);
    assign hit_t0 = word_ok && (idx == dram_map_pkg::IDX_BANK0_TIME);
    assign hit_t1 = word_ok && (idx == dram_map_pkg::IDX_BANK1_TIME);
    assign hit_size = word_ok && (idx == dram_map_pkg::IDX_BANK_SIZE);
    assign hit_stat = word_ok && (idx == dram_map_pkg::IDX_STATUS);
    assign mapped = hit_ilv || hit_page || hit_t0 || hit_t1 || hit_size || hit_stat;
    assign apb_setup = I_PSEL && !I_PENABLE;
    assign O_PREADY = I_PSEL && I_PENABLE;
    assign O_PSLVERR = O_PREADY && !mapped;
    assign apb_wr = O_PREADY && I_PWRITE && mapped;

    // ********************************************************
    // Registers
    // ********************************************************
    logic [7:0] ilv_ctrl_q;
    logic [7:0] page_ctrl_q;
    logic [7:0] bank_time_q [2];
    logic [7:0] bank_size_q;
    logic pipe_strap_q;
    logic strap_done_q;

    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            ilv_ctrl_q <= dram_map_pkg::ILV_CTRL_RST;
            page_ctrl_q <= dram_map_pkg::PAGE_CTRL_RST;
            bank_time_q[0] <= dram_map_pkg::BANK_TIME_RST;
            bank_time_q[1] <= dram_map_pkg::BANK_TIME_RST;
            bank_size_q <= dram_map_pkg::BANK_SIZE_RST;
        end else if (apb_wr) begin
            if (hit_ilv) begin
                ilv_ctrl_q <= I_PWDATA[7:0]; // [R4]
            end
            if (hit_page) begin
                page_ctrl_q <= I_PWDATA[7:0]; // [R7]
            end
            if (hit_t0) begin
                bank_time_q[0] <= I_PWDATA[7:0];
            end
            if (hit_t1) begin
                bank_time_q[1] <= I_PWDATA[7:0]; // [R10]
            end
            if (hit_size) begin
                bank_size_q <= I_PWDATA[7:0];
            end
        end
    end

    // Strap is caught once after reset release and then held
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            pipe_strap_q <= 1'b0;
            strap_done_q <= 1'b0;
        end else if (!strap_done_q) begin
            pipe_strap_q <= I_PIPELINE_STRAP; // [R3]
            strap_done_q <= 1'b1;
        end
    end

    logic page_en;
    assign page_en = !page_ctrl_q[dram_map_pkg::PAGE_DIS_BIT]; // [R7]
    assign O_PIPE_ACTIVE = pipe_strap_q && !I_CACHE_EN; // [R2] [R3]
    assign O_COLUMN_STROBE_ENABLES = ilv_ctrl_q[dram_map_pkg::ILV_EN_BIT]; // [R4]

    // ********************************************************
    // Bank map
    // ********************************************************
    logic [AW-1:0] cur_addr_q;
    logic [5:0] start0;
    logic [5:0] start1;
    logic ilv_act;
    logic map_bank;
    logic map_hit;
    logic [AW-1:0] map_tag;

    dram_bank_map #(
        .AW(AW),
        .PAGE_BITS(PAGE_BITS)
    ) u_map (
        .i_size0(bank_size_q[dram_map_pkg::SIZE0_LSB +: 2]),
        .i_size1(bank_size_q[dram_map_pkg::SIZE1_LSB +: 2]),
        .i_ilv_req(O_COLUMN_STROBE_ENABLES),
        .i_addr(cur_addr_q),
        .o_start0(start0),
        .o_start1(start1),
        .o_ilv(ilv_act),
        .o_bank(map_bank),
        .o_hit(map_hit),
        .o_tag(map_tag)
    );

    // ********************************************************
    // Bank timers
    // ********************************************************
    logic [1:0] t_start;
    logic [1:0] t_close;
    logic [1:0] t_hit;
    logic [1:0] t_avail;
    logic [1:0] t_open;
    logic [1:0] t_done;
    logic [AW-1:0] open_tag_q [2];

    for (genvar b = 0; b < 2; b++) begin : g_bank
        assign t_hit[b] = t_open[b] && (open_tag_q[b] == map_tag);
        dram_bank_timer #(
            .CW(TW)
        ) u_timer (
            .i_clk(I_CLK),
            .i_nrst(I_NRST),
            .i_start(t_start[b]),
            .i_hit(t_hit[b]),
            .i_close(t_close[b]),
            .i_page_en(page_en),
            .i_waits(bank_time_q[b][dram_map_pkg::WAIT_LSB +: TW]), // [R10] [R12]
            .i_pre(bank_time_q[b][dram_map_pkg::PRE_LSB +: TW]), // [R10] [R12]
            .o_avail(t_avail[b]),
            .o_open(t_open[b]),
            .o_done(t_done[b]),
            .o_ras_n(O_RAS_N[b]) // [R13]
        );
    end

    // ********************************************************
    // Request sequencing
    // ********************************************************
    logic cur_v_q;
    logic cur_v_d;
    logic [AW-1:0] cur_addr_d;
    logic nxt_v_q;
    logic nxt_v_d;
    logic [AW-1:0] nxt_addr_q;
    logic [AW-1:0] nxt_addr_d;
    logic run_q;
    logic run_d;
    logic bank_q;
    logic accept;
    logic go;
    logic miss;
    logic finish;
    logic sel_hit;

    // A second address is taken early only in pipeline mode
    assign accept = I_ADS && (!cur_v_q || (O_PIPE_ACTIVE && !nxt_v_q)); // [R1]
    assign sel_hit = t_hit[map_bank];
    assign miss = cur_v_q && !run_q && !map_hit;
    assign go = cur_v_q && !run_q && map_hit && t_avail[map_bank]
        && (!t_open[map_bank] || sel_hit); // [R13]
    assign t_start = go ? (map_bank ? 2'b10 : 2'b01) : 2'b00; // [R13]
    assign t_close[0] = cur_v_q && !run_q && map_hit && !map_bank && t_open[0] && !t_hit[0];
    assign t_close[1] = cur_v_q && !run_q && map_hit && map_bank && t_open[1] && !t_hit[1];
    assign finish = (run_q && t_done[bank_q]) || miss;
    assign O_READY = finish;

    always_comb begin
        cur_v_d = cur_v_q;
        cur_addr_d = cur_addr_q;
        nxt_v_d = nxt_v_q;
        nxt_addr_d = nxt_addr_q;
        run_d = run_q;
        if (go) begin
            run_d = 1'b1;
        end
        if (finish) begin
            cur_v_d = nxt_v_q;
            cur_addr_d = nxt_addr_q;
            nxt_v_d = 1'b0;
            run_d = 1'b0;
        end
        if (accept) begin
            if (!cur_v_q || (finish && !nxt_v_q)) begin
                cur_v_d = 1'b1;
                cur_addr_d = I_ADDR;
            end else begin
                nxt_v_d = 1'b1; // [R1]
                nxt_addr_d = I_ADDR;
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            cur_v_q <= 1'b0;
            cur_addr_q <= '0;
            nxt_v_q <= 1'b0;
            nxt_addr_q <= '0;
            run_q <= 1'b0;
            bank_q <= 1'b0;
        end else begin
            cur_v_q <= cur_v_d;
            cur_addr_q <= cur_addr_d;
            nxt_v_q <= nxt_v_d;
            nxt_addr_q <= nxt_addr_d;
            run_q <= run_d;
            if (go) begin
                bank_q <= map_bank;
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            open_tag_q[0] <= '0;
            open_tag_q[1] <= '0;
        end else if (go) begin
            open_tag_q[map_bank] <= map_tag; // [R8]
        end
    end

    // ********************************************************
    // Read data
    // ********************************************************
    logic [31:0] status;

    assign status = (32'(O_PIPE_ACTIVE) << dram_map_pkg::STAT_PIPE_BIT)
        | (32'(pipe_strap_q) << dram_map_pkg::STAT_STRAP_BIT)
        | (32'(ilv_act) << dram_map_pkg::STAT_ILV_BIT)
        | (32'(page_en) << dram_map_pkg::STAT_PAGE_BIT)
        | (32'(start0) << dram_map_pkg::STAT_START0_LSB)
        | (32'(start1) << dram_map_pkg::STAT_START1_LSB);
    assign rd_data = hit_ilv ? {24'h000000, ilv_ctrl_q}
        : hit_page ? {24'h000000, page_ctrl_q}
        : hit_t0 ? {24'h000000, bank_time_q[0]}
        : hit_t1 ? {24'h000000, bank_time_q[1]}
        : hit_size ? {24'h000000, bank_size_q}
        : hit_stat ? status : 32'h00000000;

    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            prdata_q <= 32'h00000000;
        end else if (apb_setup) begin
            prdata_q <= rd_data;
        end
    end
    assign O_PRDATA = prdata_q;

    // ********************************************************
    // Checks
    // ********************************************************
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_NRST);

    sequence s_b1_start3;
        t_start[1] && !t_open[1] && (bank_time_q[1][dram_map_pkg::WAIT_LSB +: TW] == 3'h3);
    endsequence
    sequence s_b1_done4;
        !t_done[1] [*3] ##1 t_done[1];
    endsequence

    chk_strap_held: assert property (strap_done_q |=> $stable(pipe_strap_q)) // [R3]
        else $error("pipeline strap changed after capture");
    chk_pipe_cache_off: assert property (I_CACHE_EN |-> !O_PIPE_ACTIVE) // [R2]
        else $error("pipeline active with cache enabled");
    chk_early_accept: assert property (
        O_PIPE_ACTIVE && cur_v_q && !finish && !nxt_v_q && I_ADS |=> nxt_v_q
        && nxt_addr_q == $past(I_ADDR)) // [R1]
        else $error("early address not taken in pipeline mode");
    chk_column_strobe_enables_write: assert property (
        apb_wr && hit_ilv && I_PWDATA[0] |=> O_COLUMN_STROBE_ENABLES) // [R4]
        else $error("column strobe enables not set by write");
    chk_ilv_zero_start: assert property (ilv_act |-> start0 == 6'h00 && start1 == 6'h00) // [R6]
        else $error("interleaved bank start not zero");
    chk_page_row_held: assert property (
        t_done[0] && page_en |=> !O_RAS_N[0] && t_open[0]) // [R7]
        else $error("row not held open in page mode");
    chk_ilv_page_pick: assert property (
        ilv_act && map_hit |-> map_bank == cur_addr_q[PAGE_BITS]) // [R8]
        else $error("interleave bank not chosen by page bit");
    chk_stack_start: assert property (
        !ilv_act && bank_size_q[1:0] == bank_size_q[3:2] && bank_size_q[1:0] != 2'h0
        |-> start0 == 6'h00 && start1 == dram_map_pkg::bank_mb(bank_size_q[1:0])) // [R9]
        else $error("bank 1 not stacked above bank 0");
    chk_b1_waits: assert property (s_b1_start3 |=> s_b1_done4) // [R10] [R12]
        else $error("bank 1 wait count not applied");
    chk_mixed_map: assert property (
        !ilv_act && bank_size_q[1:0] == dram_map_pkg::SZ_256K
        && bank_size_q[3:2] == dram_map_pkg::SZ_4M
        |-> start0 == dram_map_pkg::bank_mb(dram_map_pkg::SZ_4M) && start1 == 6'h00) // [R11]
        else $error("mixed bank start wrong");
    chk_one_row: assert property (go |=> !O_RAS_N[bank_q] && run_q) // [R13]
        else $error("selected bank row strobe not driven");

endmodule

// ### test/cpu_bus_model.sv
`timescale 1ns/1ps
module cpu_bus_model #(
    parameter int AW = 25
) (
    input wire logic i_clk,
    input wire logic i_ready,
    input wire logic [1:0] i_ras_n,
    output logic o_ads,
    output logic [AW-1:0] o_addr
);
    initial begin
        o_ads = 1'b0;
        o_addr = '0;
    end

    // ********************************************************
    // One request, then wait for the ready pulse and note strobes
    // ********************************************************
    task automatic access(input logic [AW-1:0] a, output int lat, output logic [1:0] seen);
        @(posedge i_clk);
        o_ads <= 1'b1;
        o_addr <= a;
        @(posedge i_clk);
        o_ads <= 1'b0; // One request outstanding, next only after ready
        lat = 0;
        seen = 2'b11;
        #1;
        while (i_ready !== 1'b1 && lat < 64) begin
            seen = seen & i_ras_n;
            @(posedge i_clk);
            #1;
            lat++;
        end
        seen = seen & i_ras_n;
        @(posedge i_clk);
        o_addr <= ~a; // Released address no longer shows the old value
    endtask

    // ********************************************************
    // Two requests back to back, the second while the first runs
    // ********************************************************
    task automatic pipe_pair(input logic [AW-1:0] a, input logic [AW-1:0] b, output int lat,
        output int pulses);
        @(posedge i_clk);
        o_ads <= 1'b1;
        o_addr <= a;
        @(posedge i_clk);
        o_addr <= b; // Next address presented early
        @(posedge i_clk);
        o_ads <= 1'b0;
        lat = 1;
        pulses = 0;
        while (pulses < 2 && lat < 64) begin
            #1;
            if (i_ready === 1'b1) begin
                pulses++;
            end
            if (pulses < 2) begin
                @(posedge i_clk);
                lat++;
            end
        end
        @(posedge i_clk);
        o_addr <= ~b;
    endtask
endmodule

// ### test/dram_mode_mapper_tb.sv
`timescale 1ns/1ps
module dram_mode_mapper_tb;
    logic clk, nrst, psel, penable, pwrite, pready, pslverr, cache_en, ready, csen, pipe;
    logic [9:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] ras_n, seen;
    logic ads, err, strap;
    logic [24:0] addr;
    int failures = 0, num_checks = 0, cycles = 0, lat, pulses;

    dram_mode_mapper uut (.I_CLK(clk), .I_NRST(nrst), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .I_ADS(ads), .I_ADDR(addr),
        .I_PIPELINE_STRAP(strap), .I_CACHE_EN(cache_en), .O_READY(ready), .O_RAS_N(ras_n),
        .O_COLUMN_STROBE_ENABLES(csen), .O_PIPE_ACTIVE(pipe));
    cpu_bus_model cpu (.i_clk(clk), .i_ready(ready), .i_ras_n(ras_n), .o_ads(ads),
        .o_addr(addr));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic conclude();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles > 5000) begin
            failures++;
            conclude();
        end
    end

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // ********************************************************
    // Scenarios
    // ********************************************************
    task automatic reset_values();
        apb(1'b0, 10'h064, 32'h0);
        chk("ilv_ctrl", rd, 32'h00000000);
        apb(1'b0, 10'h070, 32'h0);
        chk("page_ctrl", rd, 32'h00000010);
        apb(1'b0, 10'h084, 32'h0);
        chk("bank1_time", rd, 32'h00000033);
        apb(1'b0, 10'h3F0, 32'h0);
        chk("unmapped_err", {31'h0, err}, 32'h1);
    endtask

    task automatic pipe_strap();
        chk("pipe_active", {31'h0, pipe}, 32'h1);
        apb(1'b0, 10'h08C, 32'h0);
        chk("status_strap", {30'h0, rd[1:0]}, 32'h3);
        cache_en <= 1'b1;
        strap <= 1'b0;
        @(posedge clk);
        #1;
        chk("pipe_cache_off", {31'h0, pipe}, 32'h0);
        apb(1'b0, 10'h08C, 32'h0);
        chk("strap_held", {31'h0, rd[1]}, 32'h1);
    endtask

    task automatic map_table();
        logic [3:0] sz [5] = '{4'h9, 4'hD, 4'hE, 4'hA, 4'hA};
        logic [11:0] st [5] = '{12'h100, 12'h400, 12'h004, 12'h004, 12'h000};
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, 10'h064, {31'h0, i == 4});
            #1;
            chk("column_strobe_enables", {31'h0, csen}, {31'h0, i == 4});
            apb(1'b1, 10'h088, {28'h0, sz[i]});
            apb(1'b0, 10'h08C, 32'h0);
            chk("bank_starts", {20'h0, rd[13:8], rd[21:16]}, {20'h0, st[i]});
            chk("ilv_active", {31'h0, rd[2]}, {31'h0, i == 4});
        end
        apb(1'b1, 10'h064, 32'h0);
    endtask

    task automatic page_enable();
        apb(1'b1, 10'h070, 32'h0);
        apb(1'b0, 10'h08C, 32'h0);
        chk("page_on", {31'h0, rd[3]}, 32'h1);
        apb(1'b1, 10'h070, 32'h10);
    endtask

    task automatic cpu_access();
        apb(1'b1, 10'h080, 32'h33);
        cpu.access(25'h0400000, lat, seen);
        chk("bank1_reset_latency", lat, 32'd4);
        chk("bank1_reset_ras", {30'h0, seen}, 32'h1);
        apb(1'b1, 10'h084, 32'h31);
        cpu.access(25'h0400000, lat, seen);
        chk("bank1_latency", lat, 32'd2);
        chk("bank1_ras", {30'h0, seen}, 32'h1);
        cpu.access(25'h0000100, lat, seen);
        chk("bank0_latency", lat, 32'd4);
        chk("bank0_ras", {30'h0, seen}, 32'h2);
        cpu.access(25'h1000000, lat, seen);
        chk("hole_latency", lat, 32'd0);
        chk("hole_ras", {30'h0, seen}, 32'h3);
        apb(1'b1, 10'h070, 32'h0);
        cpu.access(25'h0000100, lat, seen);
        chk("page_open_latency", lat, 32'd4);
        cpu.access(25'h0000104, lat, seen);
        chk("page_hit_latency", lat, 32'd1);
        chk("page_hit_ras", {30'h0, seen}, 32'h2);
        apb(1'b1, 10'h070, 32'h10);
    endtask

    task automatic pipeline_pair();
        cache_en <= 1'b0;
        repeat (8) @(posedge clk);
        chk("pipe_restored", {31'h0, pipe}, 32'h1);
        cpu.pipe_pair(25'h0000100, 25'h0400000, lat, pulses);
        chk("pipe_pair_latency", lat, 32'd7);
        chk("pipe_pair_pulses", pulses, 32'd2);
    endtask

    initial begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        cache_en = 1'b0;
        strap = 1'b1;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        reset_values();
        pipe_strap();
        map_table();
        page_enable();
        cpu_access();
        pipeline_pair();
        conclude();
    end
endmodule
